// [design/wdtu_consts.svh]
// Purpose: Offsets, fields, reset values and timing counts of the watchdog timer unit
// Assumes: Included by the counter and top design files by its bare name; the package and synchroniser do not include it
// Notes: Definitions only
//
// Contract
// - Awake time-out without a clear-watchdog instruction raises a system reset
// - Counter advances on the 31 kHz low-frequency oscillator; 1 ms base unit
// - Enable config 11: always active, sleep included, software bit ignored
// - Enable config 10: active awake, disabled asleep, software bit ignored
// - Enable config 01: software bit alone turns watchdog on or off
// - Five-bit period field in control bits 5..1 picks 1 ms to 256 s
// - Any reset loads the period default code, nominally two seconds
// - Counter clears on reset, clear, sleep entry/exit, osc fail, disable, start-up timer
// - Sleep entry clears then counting resumes if enabled; sleep exit clears again
// - Crystal clock wake: held clear until start-up timer ends; else one clear
// - Sleep time-out wakes, no reset; time-out, power-down, watchdog-reset flags record
// - Internal oscillator divider changes leave the count alone
// - Codes 0..10010 double from 1:32 to 1:8388608; higher codes give 1:32
`ifndef WDTU_CONSTS_SVH
`define WDTU_CONSTS_SVH

// Register byte offsets
`define WDTU_ADDR_CONTROL 12'h000
`define WDTU_ADDR_STATUS 12'h004
`define WDTU_ADDR_IRQ_STATUS 12'h008
`define WDTU_ADDR_IRQ_MASK 12'h00c

// Control fields
`define WDTU_CTL_SWEN_BIT 0
`define WDTU_CTL_PS_LSB 1
`define WDTU_CTL_PS_MSB 5
`define WDTU_PS_RESET 5'h0b
`define WDTU_SWEN_RESET 1'b0

// Status fields
`define WDTU_ST_ASLEEP_BIT 0
`define WDTU_ST_ACTIVE_BIT 1
`define WDTU_ST_TO_N_BIT 2
`define WDTU_ST_PD_N_BIT 3
`define WDTU_ST_WATCHDOG_RESET_FLAG_N_N_BIT 4

// Interrupt bits
`define WDTU_IRQ_W 2
`define WDTU_IRQ_AWAKE_TO 0
`define WDTU_IRQ_SLEEP_TO 1

// Prescale: ratio is 2 to the power (code + 5)
`define WDTU_MIN_LOG2 5
`define WDTU_MAX_CODE 5'h12
`define WDTU_CNT_W 23

// Time base
`define WDTU_LFOSC_HZ 31000
`define WDTU_BASE_INTERVAL_US 1000
`define WDTU_BASE_TICKS ((`WDTU_LFOSC_HZ * `WDTU_BASE_INTERVAL_US) / 1000000)

`endif

// [design/wdtu_pkg.sv]
// Purpose: Types of the watchdog timer unit
// Assumes: Nothing
// Notes: Constants live in wdtu_consts.svh
package wdtu_pkg;

    // Configuration-word enable modes
    typedef enum logic [1:0] {
        WDTU_MODE_OFF = 2'b00,
        WDTU_MODE_SW = 2'b01,
        WDTU_MODE_NOSLEEP = 2'b10,
        WDTU_MODE_ON = 2'b11
    } wdtu_mode_e;

    // Power state as seen by the watchdog
    typedef enum logic [1:0] {
        WDTU_ST_AWAKE = 2'b00,
        WDTU_ST_ASLEEP = 2'b01,
        WDTU_ST_OST_HOLD = 2'b10
    } wdtu_state_e;

endpackage

// [design/wdtu_sync.sv]
// Purpose: Two-flop synchroniser for asynchronous levels
// Assumes: Input comes from outside the pclk domain
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module wdtu_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync_out;

    // Shift one stage per edge
    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule

// [design/wdtu_count.sv]
// Purpose: Watchdog prescale counter, one step per oscillator tick
// Assumes: tick is a one-cycle enable in the pclk domain
// Notes: Clear has priority over counting
`timescale 1ns/1ps
`include "wdtu_consts.svh"
module wdtu_count #(
    parameter int CNT_W = `WDTU_CNT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic clear,
    input wire logic [4:0] period_code,
    output logic timeout
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic next_timeout;

    // Codes above the table, 11111 included, fall back to 1:32
    function automatic logic [CNT_W-1:0] last_count(input logic [4:0] code);
        logic [4:0] eff;
        eff = (code > `WDTU_MAX_CODE) ? 5'h00 : code;
        last_count = CNT_W'((64'h1 << (eff + `WDTU_MIN_LOG2)) - 64'h1);
    endfunction

    // The counter must hold the largest ratio
    if (CNT_W < `WDTU_CNT_W) begin : g_bad_width
        $error("wdtu_count: CNT_W too small for the largest prescale");
    end

    // Count ticks, wrap and pulse at the selected ratio
    always_comb begin
        next_count = count;
        next_timeout = 1'b0;
        if (clear) begin
            next_count = '0;
        end else if (tick) begin
            if (count >= last_count(period_code)) begin
                next_count = '0;
                next_timeout = 1'b1;
            end else begin
                next_count = count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            timeout <= 1'b0;
        end else begin
            count <= next_count;
            timeout <= next_timeout;
        end
    end
endmodule

// [design/wdtu_top.sv]
// Purpose: Watchdog timer unit with APB registers, modes, sleep handling and flags
// Assumes: lf_osc_clk is the raw 31 kHz oscillator, far slower than pclk; core strobes are pclk pulses
// Notes: presetn is the power-on reset; sys_reset is any other system reset
`timescale 1ns/1ps
`include "wdtu_consts.svh"
module wdtu_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lf_osc_clk,
    input wire logic [1:0] watchdog_enable_config,
    input wire logic clear_watchdog_instruction,
    input wire logic sleep_enter,
    input wire logic sleep_exit,
    input wire logic osc_fail,
    input wire logic oscillator_startup_timer,
    input wire logic sysclk_is_crystal,
    input wire logic sys_reset,
    output logic watchdog_reset,
    output logic watchdog_wake,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic watchdog_reset_flag_n,
    output logic irq
);
    logic lf_sync;
    logic lf_prev;
    logic next_lf_prev;
    logic lf_tick;
    logic timeout;
    logic active;
    logic cnt_clear;
    wdtu_pkg::wdtu_state_e state;
    wdtu_pkg::wdtu_state_e next_state;
    wdtu_pkg::wdtu_mode_e mode;
    logic [4:0] period_code;
    logic [4:0] next_period_code;
    logic software_watchdog_on;
    logic next_software_watchdog_on;
    logic [`WDTU_IRQ_W-1:0] irq_status;
    logic [`WDTU_IRQ_W-1:0] next_irq_status;
    logic [`WDTU_IRQ_W-1:0] irq_mask;
    logic [`WDTU_IRQ_W-1:0] next_irq_mask;
    logic next_timeout_flag_n;
    logic next_powerdown_flag_n;
    logic next_watchdog_reset_flag_n;
    logic next_watchdog_reset;
    logic next_watchdog_wake;
    logic [31:0] next_prdata;
    logic acc;
    logic wr;
    logic rd;
    logic hit;
    logic awake_to;
    logic sleep_to;

    // Oscillator pin crosses into pclk before the edge detector
    wdtu_sync #(
        .W(1)
    ) u_lf_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(lf_osc_clk),
        .sync_out(lf_sync)
    );

    // Rising edge of the synchronised oscillator is the tick enable
    always_comb begin
        next_lf_prev = lf_sync;
        lf_tick = lf_sync & ~lf_prev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lf_prev <= 1'b0;
        end else begin
            lf_prev <= next_lf_prev;
        end
    end

    // Mode decode; only asleep counts as sleep, the start-up hold is awake
    always_comb begin
        mode = wdtu_pkg::wdtu_mode_e'(watchdog_enable_config);
        case (mode)
            wdtu_pkg::WDTU_MODE_ON: active = 1'b1;
            wdtu_pkg::WDTU_MODE_NOSLEEP: active = (state != wdtu_pkg::WDTU_ST_ASLEEP);
            wdtu_pkg::WDTU_MODE_SW: active = software_watchdog_on;
            default: active = 1'b0;
        endcase
    end

    // Every clearing source; divider selection is deliberately not among them
    always_comb begin
        cnt_clear = sys_reset | watchdog_reset | clear_watchdog_instruction | sleep_enter | sleep_exit
            | osc_fail | ~active | oscillator_startup_timer
            | (state == wdtu_pkg::WDTU_ST_OST_HOLD);
    end

    // Prescale counter on the oscillator tick
    wdtu_count #(
        .CNT_W(`WDTU_CNT_W)
    ) u_count (
        .pclk(pclk),
        .presetn(presetn),
        .tick(lf_tick),
        .clear(cnt_clear),
        .period_code(period_code),
        .timeout(timeout)
    );

    // A clear in the same cycle as the time-out pulse cancels it
    always_comb begin
        awake_to = timeout & active & ~cnt_clear & (state != wdtu_pkg::WDTU_ST_ASLEEP);
        sleep_to = timeout & active & ~cnt_clear & (state == wdtu_pkg::WDTU_ST_ASLEEP);
    end

    // Power state tracking; crystal wake waits for the start-up timer
    always_comb begin
        next_state = state;
        case (state)
            wdtu_pkg::WDTU_ST_AWAKE: begin
                if (sleep_enter) begin
                    next_state = wdtu_pkg::WDTU_ST_ASLEEP;
                end
            end
            wdtu_pkg::WDTU_ST_ASLEEP: begin
                if (sleep_exit) begin
                    next_state = sysclk_is_crystal ? wdtu_pkg::WDTU_ST_OST_HOLD
                        : wdtu_pkg::WDTU_ST_AWAKE;
                end
            end
            wdtu_pkg::WDTU_ST_OST_HOLD: begin
                if (!oscillator_startup_timer) begin
                    next_state = wdtu_pkg::WDTU_ST_AWAKE;
                end
            end
            default: next_state = wdtu_pkg::WDTU_ST_AWAKE;
        endcase
        if (sys_reset | watchdog_reset) begin
            next_state = wdtu_pkg::WDTU_ST_AWAKE;
        end
    end

    // Reset and wake strobes, one cycle each
    always_comb begin
        next_watchdog_reset = awake_to;
        next_watchdog_wake = sleep_to;
    end

    // Flags: hardware events win over clears in the same cycle
    always_comb begin
        next_timeout_flag_n = timeout_flag_n;
        next_powerdown_flag_n = powerdown_flag_n;
        next_watchdog_reset_flag_n = watchdog_reset_flag_n;
        if (clear_watchdog_instruction) begin
            next_timeout_flag_n = 1'b1;
            next_powerdown_flag_n = 1'b1;
        end
        if (wr && paddr == `WDTU_ADDR_STATUS && pwdata[`WDTU_ST_WATCHDOG_RESET_FLAG_N_N_BIT]) begin
            next_watchdog_reset_flag_n = 1'b1;
        end
        if (sleep_enter) begin
            next_powerdown_flag_n = 1'b0;
        end
        if (awake_to | sleep_to) begin
            next_timeout_flag_n = 1'b0;
            next_watchdog_reset_flag_n = 1'b0;
        end
        if (sleep_to) begin
            next_powerdown_flag_n = 1'b0;
        end
    end

    // APB decode; zero wait states
    always_comb begin
        acc = psel & penable;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
        pready = 1'b1;
        if (paddr == `WDTU_ADDR_CONTROL) begin
            hit = 1'b1;
        end else if (paddr == `WDTU_ADDR_STATUS) begin
            hit = 1'b1;
        end else if (paddr == `WDTU_ADDR_IRQ_STATUS) begin
            hit = 1'b1;
        end else if (paddr == `WDTU_ADDR_IRQ_MASK) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
        pslverr = acc & ~hit;
    end

    // Register writes; any system reset restores control defaults
    always_comb begin
        next_period_code = period_code;
        next_software_watchdog_on = software_watchdog_on;
        next_irq_mask = irq_mask;
        if (wr && paddr == `WDTU_ADDR_CONTROL) begin
            next_period_code = pwdata[`WDTU_CTL_PS_MSB:`WDTU_CTL_PS_LSB];
            next_software_watchdog_on = pwdata[`WDTU_CTL_SWEN_BIT];
        end
        if (wr && paddr == `WDTU_ADDR_IRQ_MASK) begin
            next_irq_mask = pwdata[`WDTU_IRQ_W-1:0];
        end
        if (sys_reset | watchdog_reset) begin
            next_period_code = `WDTU_PS_RESET;
            next_software_watchdog_on = `WDTU_SWEN_RESET;
        end
    end

    // Sticky events; a read clears, a new event in that cycle survives
    always_comb begin
        next_irq_status = irq_status;
        if (rd && paddr == `WDTU_ADDR_IRQ_STATUS) begin
            next_irq_status = '0;
        end
        if (awake_to) begin
            next_irq_status[`WDTU_IRQ_AWAKE_TO] = 1'b1;
        end
        if (sleep_to) begin
            next_irq_status[`WDTU_IRQ_SLEEP_TO] = 1'b1;
        end
    end

    // Read data is registered and valid in the access cycle's next edge
    always_comb begin
        next_prdata = '0;
        if (psel && !penable && !pwrite) begin
            if (paddr == `WDTU_ADDR_CONTROL) begin
                next_prdata[`WDTU_CTL_PS_MSB:`WDTU_CTL_PS_LSB] = period_code;
                next_prdata[`WDTU_CTL_SWEN_BIT] = software_watchdog_on;
            end else if (paddr == `WDTU_ADDR_STATUS) begin
                next_prdata[`WDTU_ST_ASLEEP_BIT] = (state == wdtu_pkg::WDTU_ST_ASLEEP);
                next_prdata[`WDTU_ST_ACTIVE_BIT] = active;
                next_prdata[`WDTU_ST_TO_N_BIT] = timeout_flag_n;
                next_prdata[`WDTU_ST_PD_N_BIT] = powerdown_flag_n;
                next_prdata[`WDTU_ST_WATCHDOG_RESET_FLAG_N_N_BIT] = watchdog_reset_flag_n;
            end else if (paddr == `WDTU_ADDR_IRQ_STATUS) begin
                next_prdata[`WDTU_IRQ_W-1:0] = irq_status;
            end else if (paddr == `WDTU_ADDR_IRQ_MASK) begin
                next_prdata[`WDTU_IRQ_W-1:0] = irq_mask;
            end
        end else if (acc) begin
            next_prdata = prdata;
        end
    end

    // Level interrupt from unmasked sticky bits
    always_comb begin
        irq = |(irq_status & irq_mask);
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= wdtu_pkg::WDTU_ST_AWAKE;
            period_code <= `WDTU_PS_RESET;
            software_watchdog_on <= `WDTU_SWEN_RESET;
            irq_status <= '0;
            irq_mask <= '0;
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b1;
            watchdog_reset_flag_n <= 1'b1;
            watchdog_reset <= 1'b0;
            watchdog_wake <= 1'b0;
            prdata <= '0;
        end else begin
            state <= next_state;
            period_code <= next_period_code;
            software_watchdog_on <= next_software_watchdog_on;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            timeout_flag_n <= next_timeout_flag_n;
            powerdown_flag_n <= next_powerdown_flag_n;
            watchdog_reset_flag_n <= next_watchdog_reset_flag_n;
            watchdog_reset <= next_watchdog_reset;
            watchdog_wake <= next_watchdog_wake;
            prdata <= next_prdata;
        end
    end
endmodule

// [test/wdtu_props.sv]
// Purpose: Port-level assertions for the watchdog timer unit
// Assumes: Bound to wdtu_top; one clock domain
// Notes: Output pulses lag the internal time-out by one cycle
`timescale 1ns/1ps
module wdtu_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] watchdog_enable_config,
    input wire logic clear_watchdog_instruction,
    input wire logic osc_fail,
    input wire logic sys_reset,
    input wire logic oscillator_startup_timer,
    input wire logic watchdog_reset,
    input wire logic watchdog_wake,
    input wire logic timeout_flag_n,
    input wire logic powerdown_flag_n,
    input wire logic watchdog_reset_flag_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Events are single pulses and never both at once
    reset_pulse_a: assert property (watchdog_reset |=> !watchdog_reset)
        else $error("reset pulse longer than one cycle");
    wake_pulse_a: assert property (watchdog_wake |=> !watchdog_wake)
        else $error("wake pulse longer than one cycle");
    one_event_a: assert property (!(watchdog_reset && watchdog_wake))
        else $error("reset and wake together");
    // Flags record the event within a cycle
    reset_flags_a: assert property (watchdog_reset |-> ##[0:1] (!timeout_flag_n && !watchdog_reset_flag_n))
        else $error("awake time-out flags not recorded");
    wake_flags_a: assert property (watchdog_wake |-> ##[0:1] (!timeout_flag_n && !powerdown_flag_n))
        else $error("sleep time-out flags not recorded");
    // Modes that forbid events; eight cycles when off, three in off-in-sleep mode, let an in-flight pulse drain
    off_mode_a: assert property ((watchdog_enable_config == 2'b00) [*8] |-> !(watchdog_reset || watchdog_wake))
        else $error("event while permanently off");
    nosleep_mode_a: assert property ((watchdog_enable_config == 2'b10) [*3] |-> !watchdog_wake)
        else $error("wake in off-in-sleep mode");
    // A clear source in the time-out cycle cancels the output
    clear_cancel_a: assert property ((clear_watchdog_instruction || osc_fail || sys_reset) |=>
        !(watchdog_reset || watchdog_wake)) else $error("event right after a clear");
    ost_hold_a: assert property (oscillator_startup_timer [*2] |-> !(watchdog_reset || watchdog_wake))
        else $error("event while start-up timer runs");
endmodule
bind wdtu_top wdtu_props u_props (.pclk, .presetn, .watchdog_enable_config, .clear_watchdog_instruction, .osc_fail,
    .sys_reset, .oscillator_startup_timer, .watchdog_reset, .watchdog_wake, .timeout_flag_n, .powerdown_flag_n,
    .watchdog_reset_flag_n);

// [test/wdtu_core_model.sv]
// Purpose: Core, sleep control and reset logic facing the watchdog
// Assumes: Strobes are one pclk wide, launched after a rising edge
// Notes: Oscillator runs far above 31 kHz so that runs stay short
`timescale 1ns/1ps
module wdtu_core_model (
    input wire logic pclk,
    output logic lf_osc_clk,
    output logic clear_watchdog_instruction,
    output logic sleep_enter,
    output logic sleep_exit,
    output logic osc_fail,
    output logic sys_reset,
    output logic oscillator_startup_timer,
    output logic sysclk_is_crystal
);
    logic [4:0] strobe = 5'h00;
    // Order: clear, sleep entry, sleep exit, oscillator fail, system reset
    assign {sys_reset, osc_fail, sleep_exit, sleep_enter, clear_watchdog_instruction} = strobe;
    // Free-running; odd offset keeps its edges off the pclk edges
    initial begin
        oscillator_startup_timer = 1'b0;
        sysclk_is_crystal = 1'b0;
        lf_osc_clk = 1'b0;
        #7;
        forever #150 lf_osc_clk = ~lf_osc_clk;
    end
    task automatic pulse(input logic [4:0] m);
        @(posedge pclk);
        strobe <= m;
        @(posedge pclk);
        strobe <= 5'h00;
    endtask
    task automatic levels(input logic run, input logic xtal);
        @(posedge pclk);
        oscillator_startup_timer <= run;
        sysclk_is_crystal <= xtal;
    endtask
endmodule

// [test/watchdog_timer_unit_test.sv]
// Purpose: Self-checking bench for the watchdog timer unit
// Assumes: Core model supplies strobes and a sped-up oscillator
// Notes: Time-outs are measured in oscillator edges seen here
`timescale 1ns/1ps
`include "wdtu_consts.svh"
module watchdog_timer_unit_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [1:0] watchdog_enable_config;
    logic [31:0] prdata;
    logic pready, pslverr, lf_osc_clk, clear_watchdog_instruction, sleep_enter, sleep_exit, osc_fail;
    logic sys_reset, oscillator_startup_timer, sysclk_is_crystal, watchdog_reset, watchdog_wake;
    logic timeout_flag_n, powerdown_flag_n, watchdog_reset_flag_n, irq, err, lf_q;
    logic [31:0] rd;
    logic [1:0] got;
    int ticks = 0;
    int start = 0;
    int error_cnt = 0;
    int samples_checked = 0;

    wdtu_core_model u_core (.pclk, .lf_osc_clk, .clear_watchdog_instruction, .sleep_enter, .sleep_exit, .osc_fail,
        .sys_reset, .oscillator_startup_timer, .sysclk_is_crystal);
    wdtu_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .lf_osc_clk, .watchdog_enable_config, .clear_watchdog_instruction, .sleep_enter, .sleep_exit, .osc_fail,
        .oscillator_startup_timer, .sysclk_is_crystal, .sys_reset, .watchdog_reset, .watchdog_wake,
        .timeout_flag_n, .powerdown_flag_n, .watchdog_reset_flag_n, .irq);

    always #10 pclk = ~pclk;
    // Count oscillator rising edges as the reference time base
    always @(posedge pclk) begin
        lf_q <= lf_osc_clk;
        if (lf_osc_clk && !lf_q) ticks <= ticks + 1;
    end

    task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask
    // One APB transfer; holds everything until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Strobe mid-way between oscillator edges so no tick straddles the clear
    task automatic sync(input logic [4:0] m);
        @(negedge lf_osc_clk);
        u_core.pulse(m);
        start = ticks;
    endtask
    task automatic expect_ev(input logic [1:0] e, input int n);
        got = 2'b00;
        for (int i = 0; i < (n + 4) * 15 && got == 2'b00; i++) begin
            @(posedge pclk);
            #1;
            got = {watchdog_wake, watchdog_reset};
        end
        check({30'h0, got}, {30'h0, e}, "event kind");
        if (e != 2'b00) check(ticks - start, n, "ticks to time-out");
        @(posedge pclk);
        #1;
    endtask
    task automatic t_regs;
        apb(1'b0, `WDTU_ADDR_CONTROL, 32'h0);
        check(rd, 32'h16, "control reset");
        apb(1'b1, `WDTU_ADDR_CONTROL, 32'hff);
        apb(1'b0, `WDTU_ADDR_CONTROL, 32'h0);
        check(rd, 32'h3f, "control write");
        u_core.pulse(5'h10);
        apb(1'b0, `WDTU_ADDR_CONTROL, 32'h0);
        check(rd, 32'h16, "control after reset");
        apb(1'b0, 12'h010, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped error");
        $display("register test done");
    endtask
    task automatic t_periods;
        logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h13, 5'h1f};
        foreach (codes[i]) begin
            apb(1'b1, `WDTU_ADDR_CONTROL, {26'h0, codes[i], 1'b0});
            sync(5'h01);
            expect_ev(2'b01, codes[i] > 5'h12 ? 32 : 32 << codes[i]);
            check({29'h0, timeout_flag_n, watchdog_reset_flag_n, irq}, 32'h0, "awake flags, masked irq");
        end
        apb(1'b0, `WDTU_ADDR_CONTROL, 32'h0);
        check(rd, 32'h16, "period restored");
        apb(1'b1, `WDTU_ADDR_STATUS, 32'h10);
        u_core.pulse(5'h01);
        #1; // Flags settle only after the pulse's closing edge
        check({29'h0, timeout_flag_n, powerdown_flag_n, watchdog_reset_flag_n}, 32'h7, "flags restored");
        $display("period test done");
    endtask
    task automatic t_modes;
        // Layout: mode[5:4], software enable[3], asleep[2], expected {wake, reset}[1:0]
        logic [5:0] cases [8] = '{6'h08, 6'h0c, 6'h10, 6'h1e, 6'h19, 6'h21, 6'h2c, 6'h36};
        foreach (cases[i]) begin
            @(posedge pclk);
            watchdog_enable_config <= cases[i][5:4];
            apb(1'b1, `WDTU_ADDR_CONTROL, {31'h0, cases[i][3]});
            u_core.pulse(5'h01);
            sync(cases[i][2] ? 5'h02 : 5'h01);
            expect_ev(cases[i][1:0], cases[i][1:0] == 2'b00 ? 40 : 32);
            if (cases[i][2]) begin
                check({30'h0, timeout_flag_n, powerdown_flag_n}, {30'h0, !cases[i][1], 1'b0}, "sleep flags");
                u_core.pulse(5'h04);
            end
        end
        @(posedge pclk);
        watchdog_enable_config <= 2'b11;
        $display("mode test done");
    endtask
    task automatic t_clears;
        apb(1'b1, `WDTU_ADDR_CONTROL, 32'h0);
        sync(5'h01);
        while (ticks - start < 20) @(posedge pclk);
        sync(5'h08);
        expect_ev(2'b01, 32);
        apb(1'b1, `WDTU_ADDR_CONTROL, 32'h0);
        u_core.levels(1'b1, 1'b1);
        u_core.pulse(5'h02);
        u_core.pulse(5'h04);
        expect_ev(2'b00, 40);
        @(negedge lf_osc_clk);
        u_core.levels(1'b0, 1'b1);
        start = ticks;
        expect_ev(2'b01, 32);
        u_core.levels(1'b0, 1'b0);
        $display("clear test done");
    endtask
    task automatic t_irq;
        apb(1'b0, `WDTU_ADDR_IRQ_STATUS, 32'h0);
        check(rd, 32'h3, "sticky awake and sleep events");
        apb(1'b1, `WDTU_ADDR_IRQ_MASK, 32'h3);
        apb(1'b1, `WDTU_ADDR_CONTROL, 32'h0);
        sync(5'h01);
        expect_ev(2'b01, 32);
        check({31'h0, irq}, 32'h1, "irq raised");
        apb(1'b0, `WDTU_ADDR_IRQ_STATUS, 32'h0);
        check(rd, 32'h1, "irq status");
        #1;
        check({31'h0, irq}, 32'h0, "irq cleared");
        $display("interrupt test done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        // Idle bus and always-on mode while reset is held
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        watchdog_enable_config <= 2'b11;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_periods;
        t_modes;
        t_clears;
        t_irq;
        wrap_up;
    end
    // Whole run needs about 0.3 ms of simulated time
    initial begin
        #1000000;
        error_cnt++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        wrap_up;
    end
endmodule
